// [include/lcd_port_if.sv]
// Pin bundle between the host controller and the LCD host bus port
`timescale 1ns/1ns
interface lcd_port_if;
	logic [7:0] host_data_out;
	logic [7:0] host_data_oe;
	logic [7:0] dev_data_out;
	logic [7:0] dev_data_oe;
	logic [7:0] host_data_lines;
	logic       select_low_input_n;
	logic       select_high_input;
	logic       data_command_select;
	logic       init_low_input_n;
	logic       read_strobe;
	logic       write_strobe;
	logic       interface_select;
	logic       bus_style_select;
	logic       master_select;
	logic       display_clock_out;
	logic       display_clock_oe;
	logic       display_clock_io;

	// Device wins a clash; undriven lines float high as with a pull-up
	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_line
			assign host_data_lines[i] = dev_data_oe[i] ? dev_data_out[i] :
				host_data_oe[i] ? host_data_out[i] : 1'b1;
		end
	endgenerate
	assign display_clock_io = display_clock_oe ? display_clock_out : 1'b0;

	modport dev (
		input  host_data_lines, select_low_input_n, select_high_input,
		input  data_command_select, init_low_input_n, read_strobe, write_strobe,
		input  interface_select, bus_style_select, master_select, display_clock_io,
		output dev_data_out, dev_data_oe, display_clock_out, display_clock_oe
	);
	modport host (
		input  host_data_lines, display_clock_io,
		output host_data_out, host_data_oe, select_low_input_n, select_high_input,
		output data_command_select, init_low_input_n, read_strobe, write_strobe,
		output interface_select, bus_style_select, master_select
	);
endinterface

// [include/lcd_port_pkg.sv]
// Shared constants and types for the LCD host bus port and its host controller
package lcd_port_pkg;
	// Host controller register offsets (byte addresses)
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_CMD    = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;

	// CTRL fields
	localparam int CTRL_PARALLEL  = 0;
	localparam int CTRL_BUS_STYLE = 1;
	localparam int CTRL_MASTER    = 2;
	localparam int CTRL_INIT      = 3;
	localparam int CTRL_W         = 4;
	localparam logic [3:0] CTRL_RESET = 4'h1;

	// CMD fields
	localparam int CMD_DATA_LSB = 0;
	localparam int CMD_A0       = 8;
	localparam int CMD_READ     = 9;

	// STATUS fields
	localparam int STAT_BUSY     = 0;
	localparam int STAT_DUMMY    = 1;
	localparam int STAT_DATA_LSB = 8;

	// Host clock cycles, less one, per strobe phase and per serial clock half period
	localparam logic [3:0] PHASE_CYC = 4'h6;
	localparam logic [2:0] LAST_BIT  = 3'h7;
	// Link clock cycles per half period of the display clock when master
	localparam logic [3:0] CL_HALF = 4'h4;
	// Level of an undriven data line
	localparam logic [7:0] BUS_IDLE = 8'hFF;
	localparam logic [7:0] OE_ALL   = 8'hFF;
	localparam logic [7:0] OE_NONE  = 8'h00;
	localparam logic [7:0] OE_SER   = 8'hC0;
	localparam logic [7:0] BYTE_ZERO = 8'h00;

	typedef enum logic [5:0] {
		ST_IDLE   = 6'b000001,
		ST_SETUP  = 6'b000010,
		ST_STROBE = 6'b000100,
		ST_HOLD   = 6'b001000,
		ST_SLOW   = 6'b010000,
		ST_SHIGH  = 6'b100000
	} host_state_t;
endpackage

// [logic/lcd_host_bus_port.sv]
// LCD controller host bus port: parallel and serial byte intake, display reads via bus holder
`timescale 1ns/1ns
// Notes on behaviour
// - Eight-bit two-way data bus toward host
// - Static pin picks parallel or serial transfers
// - Serial: line 7 data, line 6 clock
// - Selected only when low select low, high high
// - Deselected: all eight data lines released
// - Address line high display data, low command
// - Init input low resets settings, level-sensitive
// - Bus-style pin picks enable or split strobes
// - Split style: drive bus while read low
// - Enable style: active-high enable frames cycle
// - Split style: capture on write strobe rise
// - Enable style: direction high read, low write
// - Master/slave pin sets display timing role
// - Display clock pins tied, shared clock
// - Serial MSB first, byte every eighth rise
// - Serial samples address line on eighth rise
// - Serial deselect clears shifter and counter
// - Display reads pipelined; first read is dummy
module lcd_host_bus_port
	import lcd_port_pkg::*;
(
	input  wire logic       i_link_clk,          // Link clock
	input  wire logic       i_arst_n,            // Async reset, active low
	lcd_port_if.dev         bus,                 // Host-facing pins
	input  wire logic [7:0] i_status,            // Status byte for command reads
	input  wire logic [7:0] i_display_read,      // Next display byte for the holder
	output logic      [7:0] o_byte,              // Received byte
	output logic            o_byte_is_display,   // Received byte is display data
	output logic            o_byte_valid,        // One-cycle pulse per byte
	output logic            o_display_read_taken,// Holder loaded from i_display_read
	output logic            o_display_clock,     // Display clock in use
	output logic            o_master             // Acting as timing master
);
	// Init pin joins the reset so it acts on level, not edge
	logic rst_in_n;
	logic rst_meta_n;
	logic rst_n;
	assign rst_in_n = i_arst_n & bus.init_low_input_n;

	// Enters at once, leaves on a link edge so no flop sees a late release
	always_ff @(posedge i_link_clk or negedge rst_in_n) begin
		if (!rst_in_n) begin
			rst_meta_n <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_n      <= rst_meta_n;
		end
	end

	// Two-flop synchronisers for every pin from the host side except init, which joins the reset instead
	logic [7:0] d_meta;
	logic [7:0] d_sync;
	logic [8:0] c_meta;
	logic [8:0] c_sync;
	always_ff @(posedge i_link_clk or negedge rst_n) begin
		if (!rst_n) begin
			d_meta <= 8'h00;
			d_sync <= 8'h00;
			c_meta <= 9'h000;
			c_sync <= 9'h000;
		end else begin
			d_meta <= bus.host_data_lines;
			d_sync <= d_meta;
			c_meta <= {bus.display_clock_io, bus.master_select, bus.bus_style_select,
				bus.interface_select, bus.write_strobe, bus.read_strobe,
				bus.data_command_select, bus.select_high_input, bus.select_low_input_n};
			c_sync <= c_meta;
		end
	end

	logic s_cs1_n;
	logic s_cs2;
	logic s_a0;
	logic s_rd;
	logic s_wr;
	logic s_par;
	logic s_style;
	logic s_ms;
	logic s_cl;
	assign {s_cl, s_ms, s_style, s_par, s_wr, s_rd, s_a0, s_cs2, s_cs1_n} = c_sync;

	logic sel;
	logic rd_act;
	logic rd_prev;
	logic wr_prev;
	logic scl_prev;
	assign sel = !s_cs1_n && s_cs2;
	// Read window: split style read low, enable style E high with direction high
	assign rd_act = sel && s_par && (s_style ? (s_rd && s_wr) : !s_rd);

	logic write_take;
	assign write_take = sel && s_par && (s_style ?
		(rd_prev && !s_rd && !s_wr) :
		(!wr_prev && s_wr));

	// Write history starts high, its idle level, so no edge follows reset
	always_ff @(posedge i_link_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_prev  <= 1'b0;
			wr_prev  <= 1'b1;
			scl_prev <= 1'b0;
		end else begin
			rd_prev  <= s_style ? s_rd : rd_act;
			wr_prev  <= s_wr;
			scl_prev <= d_sync[6];
		end
	end

	// Serial shifter
	logic [6:0] shreg;
	logic [2:0] bit_cnt;
	logic       scl_rise;
	assign scl_rise = !s_par && sel && d_sync[6] && !scl_prev;
	always_ff @(posedge i_link_clk or negedge rst_n) begin
		if (!rst_n) begin
			shreg   <= 7'h00;
			bit_cnt <= 3'h0;
		end else if (!sel || s_par) begin
			shreg   <= 7'h00;
			bit_cnt <= 3'h0;
		end else if (scl_rise) begin
			shreg   <= {shreg[5:0], d_sync[7]};
			bit_cnt <= bit_cnt + 3'h1;
		end
	end

	// Byte delivery, either path
	always_ff @(posedge i_link_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_byte            <= 8'h00;
			o_byte_is_display <= 1'b0;
			o_byte_valid      <= 1'b0;
		end else begin
			o_byte_valid <= 1'b0;
			if (scl_rise && bit_cnt == LAST_BIT) begin
				o_byte            <= {shreg, d_sync[7]};
				o_byte_is_display <= s_a0;
				o_byte_valid      <= 1'b1;
			end else if (write_take) begin
				o_byte            <= d_sync;
				o_byte_is_display <= s_a0;
				o_byte_valid      <= 1'b1;
			end
		end
	end

	// Bus holder: a display read shows the held byte, then refills at its end
	logic [7:0] holder;
	logic       rd_end;
	logic       rd_was;
	logic       a0_rd;
	assign rd_end = rd_was && !rd_act;
	always_ff @(posedge i_link_clk or negedge rst_n) begin
		if (!rst_n) begin
			holder               <= 8'h00;
			rd_was               <= 1'b0;
			a0_rd                <= 1'b0;
			o_display_read_taken <= 1'b0;
		end else begin
			rd_was               <= rd_act;
			o_display_read_taken <= 1'b0;
			if (rd_act) begin
				a0_rd <= s_a0;
			end
			if (rd_end && a0_rd) begin
				holder               <= i_display_read;
				o_display_read_taken <= 1'b1;
			end
		end
	end

	// Drivers; serial mode never drives, deselect releases all lines
	always_ff @(posedge i_link_clk or negedge rst_n) begin
		if (!rst_n) begin
			bus.dev_data_out <= 8'h00;
			bus.dev_data_oe  <= OE_NONE;
		end else begin
			bus.dev_data_out <= s_a0 ? holder : i_status;
			bus.dev_data_oe  <= rd_act ? OE_ALL : OE_NONE;
		end
	end

	// Display clock: master divides the link clock, slave follows the shared pin
	logic [3:0] cl_cnt;
	always_ff @(posedge i_link_clk or negedge rst_n) begin
		if (!rst_n) begin
			cl_cnt                <= 4'h0;
			bus.display_clock_out <= 1'b0;
			bus.display_clock_oe  <= 1'b0;
			o_display_clock       <= 1'b0;
			o_master              <= 1'b0;
		end else begin
			o_master             <= s_ms;
			bus.display_clock_oe <= s_ms;
			if (cl_cnt == CL_HALF - 4'h1) begin
				cl_cnt                <= 4'h0;
				bus.display_clock_out <= !bus.display_clock_out;
			end else begin
				cl_cnt <= cl_cnt + 4'h1;
			end
			// Divider runs as slave too, so taking the master role needs no restart
			o_display_clock <= s_ms ? bus.display_clock_out : s_cl;
		end
	end
endmodule

// [logic/lcd_host_ctrl.sv]
// Host controller: APB registers drive parallel or serial transfers to the LCD port
`timescale 1ns/1ns
module lcd_host_ctrl
	import lcd_port_pkg::*;
(
	input  wire logic        i_clk,     // System clock
	input  wire logic        i_arst_n,  // Async reset, active low
	input  wire logic        i_psel,    // APB select
	input  wire logic        i_penable, // APB enable
	input  wire logic        i_pwrite,  // APB direction
	input  wire logic [7:0]  i_paddr,   // APB byte address
	input  wire logic [31:0] i_pwdata,  // APB write data
	output logic      [31:0] o_prdata,  // APB read data
	output logic             o_pready,  // APB ready
	output logic             o_pslverr, // APB error, unmapped address
	lcd_port_if.host         bus        // Pins toward the LCD port
);
	logic [CTRL_W-1:0] ctrl;
	logic [7:0]  cmd_data, rd_data;
	logic        cmd_a0, cmd_read, busy, dummy, primed;
	host_state_t state;
	logic [3:0]  cnt;
	logic [2:0]  bit_idx;
	logic [7:0]  din_meta, din_sync;

	logic acc, start, mapped;
	assign acc    = i_psel && i_penable && o_pready;
	assign mapped = i_paddr == OFS_CTRL || i_paddr == OFS_CMD || i_paddr == OFS_STATUS;
	// Serial mode cannot read back; such a command is ignored
	assign start  = acc && i_pwrite && i_paddr == OFS_CMD && !busy &&
		!(i_pwdata[CMD_READ] && !ctrl[CTRL_PARALLEL]);

	// APB slave: ready one cycle after setup
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata  <= 32'h0000_0000;
		end else begin
			o_pready  <= i_psel && !i_penable;
			o_pslverr <= i_psel && !i_penable && !mapped;
			o_prdata  <= 32'h0000_0000;
			if (i_psel && !i_penable && !i_pwrite) begin
				case (i_paddr)
					OFS_CTRL:   o_prdata <= {28'h000_0000, ctrl};
					OFS_CMD:    o_prdata <= {22'h00_0000, cmd_read, cmd_a0, cmd_data};
					OFS_STATUS: o_prdata <= {16'h0000, rd_data, 6'h00, dummy, busy};
					default:    o_prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Mode pins change only while idle, so the board sees static levels
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ctrl <= CTRL_RESET;
		end else if (acc && i_pwrite && i_paddr == OFS_CTRL && !busy) begin
			ctrl <= i_pwdata[CTRL_W-1:0];
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cmd_data <= 8'h00;
			cmd_a0   <= 1'b0;
			cmd_read <= 1'b0;
		end else if (start) begin
			cmd_data <= i_pwdata[CMD_DATA_LSB +: 8];
			cmd_a0   <= i_pwdata[CMD_A0];
			cmd_read <= i_pwdata[CMD_READ];
		end
	end

	// Read-back data comes from the other side, so synchronise it
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			din_meta <= 8'h00;
			din_sync <= 8'h00;
		end else begin
			din_meta <= bus.host_data_lines;
			din_sync <= din_meta;
		end
	end

	// First display read after any other transfer only primes the holder
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			primed <= 1'b0;
			dummy  <= 1'b0;
		end else if (start) begin
			primed <= i_pwdata[CMD_READ] && i_pwdata[CMD_A0];
			dummy  <= i_pwdata[CMD_READ] && i_pwdata[CMD_A0] && !primed;
		end
	end

	// Transfer sequencer
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state                   <= ST_IDLE;
			busy                    <= 1'b0;
			cnt                     <= 4'h0;
			bit_idx                 <= 3'h0;
			rd_data                 <= 8'h00;
			bus.select_low_input_n  <= 1'b1;
			bus.select_high_input   <= 1'b0;
			bus.data_command_select <= 1'b0;
			bus.read_strobe         <= 1'b1;
			bus.write_strobe        <= 1'b1;
			bus.host_data_out       <= 8'h00;
			bus.host_data_oe        <= OE_NONE;
		end else begin
			cnt <= cnt + 4'h1;
			case (state)
				ST_IDLE: begin
					// Idle: enable low in enable style, both strobes high in split style
					bus.read_strobe  <= !ctrl[CTRL_BUS_STYLE];
					bus.write_strobe <= 1'b1;
					if (start) begin
						busy                    <= 1'b1;
						cnt                     <= 4'h0;
						bus.select_low_input_n  <= 1'b0;
						bus.select_high_input   <= 1'b1;
						bus.data_command_select <= i_pwdata[CMD_A0];
						bus.host_data_out       <= i_pwdata[CMD_DATA_LSB +: 8];
						if (!ctrl[CTRL_PARALLEL]) begin
							bus.host_data_oe <= OE_SER;
							state            <= ST_SLOW;
							bit_idx          <= 3'h7;
						end else begin
							bus.host_data_oe <= i_pwdata[CMD_READ] ? OE_NONE : OE_ALL;
							bus.write_strobe <= ctrl[CTRL_BUS_STYLE] ? i_pwdata[CMD_READ] :
								1'b1;
							state            <= ST_SETUP;
						end
					end
				end
				ST_SETUP: begin
					if (cnt == PHASE_CYC) begin
						cnt   <= 4'h0;
						state <= ST_STROBE;
						if (ctrl[CTRL_BUS_STYLE]) begin
							bus.read_strobe <= 1'b1;
						end else if (cmd_read) begin
							bus.read_strobe <= 1'b0;
						end else begin
							bus.write_strobe <= 1'b0;
						end
					end
				end
				ST_STROBE: begin
					if (cnt == PHASE_CYC) begin
						cnt             <= 4'h0;
						state           <= ST_HOLD;
						rd_data         <= cmd_read ? din_sync : rd_data;
						bus.read_strobe <= !ctrl[CTRL_BUS_STYLE];
						bus.write_strobe <= ctrl[CTRL_BUS_STYLE] ? bus.write_strobe : 1'b1;
					end
				end
				ST_SLOW: begin
					bus.host_data_out <= {cmd_data[bit_idx], 7'h00};
					if (cnt == PHASE_CYC) begin
						cnt                  <= 4'h0;
						bus.host_data_out[6] <= 1'b1;
						state                <= ST_SHIGH;
					end
				end
				ST_SHIGH: begin
					if (cnt == PHASE_CYC) begin
						cnt     <= 4'h0;
						bit_idx <= bit_idx - 3'h1;
						state   <= (bit_idx == 3'h0) ? ST_HOLD : ST_SLOW;
						bus.host_data_out[6] <= 1'b0;
					end
				end
				ST_HOLD: begin
					if (cnt == PHASE_CYC) begin
						busy                   <= 1'b0;
						state                  <= ST_IDLE;
						bus.select_low_input_n <= 1'b1;
						bus.select_high_input  <= 1'b0;
						bus.host_data_oe       <= OE_NONE;
						bus.write_strobe       <= 1'b1;
					end
				end
				default: begin
					state <= ST_IDLE;
					busy  <= 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			bus.interface_select <= 1'b1;
			bus.bus_style_select <= 1'b0;
			bus.master_select    <= 1'b0;
			bus.init_low_input_n <= 1'b0;
		end else begin
			bus.interface_select <= ctrl[CTRL_PARALLEL];
			bus.bus_style_select <= ctrl[CTRL_BUS_STYLE];
			bus.master_select    <= ctrl[CTRL_MASTER];
			bus.init_low_input_n <= !ctrl[CTRL_INIT];
		end
	end
endmodule

// [tb/lcd_port_properties.sv]
// Pin-level checks between the host controller and the LCD port
`timescale 1ns/1ns
module lcd_port_properties
	import lcd_port_pkg::*;
(
	input  wire logic       i_clk,               // Host clock
	input  wire logic       i_link_clk,          // Link clock
	input  wire logic       i_arst_n,            // Reset, active low
	input  wire logic [7:0] dev_data_oe,         // Device data drive
	input  wire logic       display_clock_oe,    // Device clock drive
	input  wire logic       select_low_input_n,  // Select, low active
	input  wire logic       select_high_input,   // Select, high active
	input  wire logic       data_command_select, // Data or command
	input  wire logic       init_low_input_n,    // Init, low active
	input  wire logic       read_strobe,         // Read or enable
	input  wire logic       write_strobe,        // Write or direction
	input  wire logic       interface_select,    // Parallel or serial
	input  wire logic       bus_style_select,    // Enable or split
	input  wire logic       master_select        // Timing master
);
	wire logic sel = !select_low_input_n && select_high_input;

	// Pin sync takes two link edges, so levels must stand five samples
	a_oe_whole: assert property (@(posedge i_link_clk) disable iff (!i_arst_n)
		dev_data_oe == OE_NONE || dev_data_oe == OE_ALL) else $error("Partial data drive");
	a_desel_float: assert property (@(posedge i_link_clk) disable iff (!i_arst_n)
		(!sel)[*5] |-> dev_data_oe == OE_NONE) else $error("Drive while deselected");
	a_serial_float: assert property (@(posedge i_link_clk) disable iff (!i_arst_n)
		(!interface_select)[*5] |-> dev_data_oe == OE_NONE) else $error("Drive in serial");
	a_read_drive: assert property (@(posedge i_link_clk) disable iff (!i_arst_n)
		(sel && interface_select && !bus_style_select && !read_strobe && init_low_input_n)[*5]
		|-> dev_data_oe == OE_ALL) else $error("No drive during read");
	a_write_float: assert property (@(posedge i_link_clk) disable iff (!i_arst_n)
		(!write_strobe && interface_select)[*5] |-> dev_data_oe == OE_NONE)
		else $error("Drive during write");
	a_init_quiet: assert property (@(posedge i_link_clk) disable iff (!i_arst_n)
		(!init_low_input_n)[*5] |-> dev_data_oe == OE_NONE && !display_clock_oe)
		else $error("Active while init low");
	a_slave_quiet: assert property (@(posedge i_link_clk) disable iff (!i_arst_n)
		(!master_select)[*5] |-> !display_clock_oe) else $error("Slave drives clock");
	a_master_drive: assert property (@(posedge i_link_clk) disable iff (!i_arst_n)
		(master_select && init_low_input_n)[*5] |-> display_clock_oe)
		else $error("Master clock not driven");
	a_split_select: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		($fell(read_strobe) || $fell(write_strobe)) && !bus_style_select
		&& !$past(bus_style_select) |-> sel && interface_select) else $error("Strobe unselected");
	a_enable_select: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		$rose(read_strobe) && bus_style_select && $past(bus_style_select)
		|-> sel && interface_select) else $error("Enable unselected");
	a_dir_steady: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		bus_style_select && read_strobe && $past(read_strobe) |-> $stable(write_strobe))
		else $error("Direction moved in cycle");
	a_a0_steady: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		$changed(data_command_select) |-> !(sel && $past(sel))) else $error("A0 moved");
	a_mode_steady: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		sel |-> $stable(interface_select) && $stable(bus_style_select))
		else $error("Mode moved while selected");
endmodule

// [tb/test_lcd_host_bus_port.sv]
// Bench: APB host controller driving the LCD port across the pin bundle
`timescale 1ns/1ns
module test_lcd_host_bus_port;
	import lcd_port_pkg::*;
	typedef struct packed {
		logic [3:0] ctrl;
		logic [9:0] cmd;
	} row_t;
	row_t        rows [6] = '{'{4'h1, 10'h0A5}, '{4'h1, 10'h13C}, '{4'h3, 10'h181},
		'{4'h3, 10'h07E}, '{4'h0, 10'h05A}, '{4'h0, 10'h1C3}};
	logic        i_clk = 1'b0;
	logic        i_link_clk = 1'b0;
	logic        i_arst_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [7:0]  display_byte = 8'h4B;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [7:0]  o_byte;
	logic        o_byte_is_display;
	logic        o_byte_valid;
	logic        o_display_read_taken;
	logic        o_display_clock;
	logic        o_master;
	logic [31:0] rd;
	logic        err;
	logic [7:0]  got_byte = 8'h00;
	logic        got_disp = 1'b0;
	int          n_bytes = 0;
	int          n_taken = 0;
	int          toggles;
	int          n_errors = 0;
	int          checked = 0;

	lcd_port_if bus ();
	lcd_host_ctrl u_lcd_host_ctrl (
		.i_clk     (i_clk),
		.i_arst_n  (i_arst_n),
		.i_psel    (psel),
		.i_penable (penable),
		.i_pwrite  (pwrite),
		.i_paddr   (paddr),
		.i_pwdata  (pwdata),
		.o_prdata  (prdata),
		.o_pready  (pready),
		.o_pslverr (pslverr),
		.bus       (bus)
	);
	lcd_host_bus_port u_lcd_host_bus_port (
		.i_link_clk           (i_link_clk),
		.i_arst_n             (i_arst_n),
		.bus                  (bus),
		.i_status             (8'h96),
		.i_display_read       (display_byte),
		.o_byte               (o_byte),
		.o_byte_is_display    (o_byte_is_display),
		.o_byte_valid         (o_byte_valid),
		.o_display_read_taken (o_display_read_taken),
		.o_display_clock      (o_display_clock),
		.o_master             (o_master)
	);
	lcd_port_properties u_lcd_port_properties (
		.i_clk               (i_clk),
		.i_link_clk          (i_link_clk),
		.i_arst_n            (i_arst_n),
		.dev_data_oe         (bus.dev_data_oe),
		.display_clock_oe    (bus.display_clock_oe),
		.select_low_input_n  (bus.select_low_input_n),
		.select_high_input   (bus.select_high_input),
		.data_command_select (bus.data_command_select),
		.init_low_input_n    (bus.init_low_input_n),
		.read_strobe         (bus.read_strobe),
		.write_strobe        (bus.write_strobe),
		.interface_select    (bus.interface_select),
		.bus_style_select    (bus.bus_style_select),
		.master_select       (bus.master_select)
	);

	initial begin
		forever #50 i_clk = ~i_clk;
	end
	// 125 ns in whole nanoseconds, offset so the domains never line up
	initial begin
		#17;
		forever begin
			#62 i_link_clk = ~i_link_clk;
			#63 i_link_clk = ~i_link_clk;
		end
	end

	always @(posedge i_link_clk) begin
		if (o_byte_valid === 1'b1) begin
			got_byte <= o_byte;
			got_disp <= o_byte_is_display;
			n_bytes  <= n_bytes + 1;
		end
		if (o_display_read_taken === 1'b1)
			n_taken <= n_taken + 1;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
		@(posedge i_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= addr;
		pwdata  <= wdata;
		@(posedge i_clk);
		penable <= 1'b1;
		// No cycle count assumed; only the watchdog ends a hung wait
		do begin
			@(posedge i_clk);
		end while (pready !== 1'b1);
		rd      = prdata;
		err     = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wait_idle();
		int n;
		n = 0;
		do begin
			apb(1'b0, OFS_STATUS, 32'h0000_0000);
			n++;
		end while (rd[STAT_BUSY] !== 1'b0 && n < 200);
		chk(32'(rd[STAT_BUSY]), 32'h0000_0000);
	endtask

	// Settle past the synchronisers, then count display clock edges
	task automatic count_clk();
		logic prev;
		repeat (8) @(posedge i_link_clk);
		toggles = 0;
		prev = o_display_clock;
		repeat (40) begin
			@(posedge i_link_clk);
			if (o_display_clock !== prev)
				toggles++;
			prev = o_display_clock;
		end
	endtask

	task automatic give_verdict();
		$display("checked=%0d n_errors=%0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		#1_000_000;
		n_errors++;
		give_verdict();
	end

	initial begin
		repeat (10) @(posedge i_clk);
		i_arst_n <= 1'b1;
		apb(1'b0, OFS_CTRL, 32'h0000_0000);
		chk(rd, 32'h0000_0001);
		apb(1'b1, 8'h0C, 32'h0000_000F);
		chk(32'(err), 32'h0000_0001);
		foreach (rows[k]) begin
			apb(1'b1, OFS_CTRL, 32'(rows[k].ctrl));
			apb(1'b1, OFS_CMD, 32'(rows[k].cmd));
			wait_idle();
			chk(32'(got_byte), 32'(rows[k].cmd[7:0]));
			chk(32'(got_disp), 32'(rows[k].cmd[8]));
			chk(n_bytes, 32'(k + 1));
		end
		// Second order and mode change arrive while busy and must be dropped
		apb(1'b1, OFS_CTRL, 32'h0000_0001);
		apb(1'b1, OFS_CMD, 32'h0000_0155);
		apb(1'b1, OFS_CMD, 32'h0000_00AA);
		apb(1'b1, OFS_CTRL, 32'h0000_0003);
		wait_idle();
		chk(32'(got_byte), 32'h0000_0055);
		chk(n_bytes, 32'h0000_0007);
		apb(1'b0, OFS_CTRL, 32'h0000_0000);
		chk(rd, 32'h0000_0001);
		apb(1'b1, OFS_CMD, 32'h0000_0200);
		wait_idle();
		chk(32'(rd[15:8]), 32'h0000_0096);
		apb(1'b1, OFS_CMD, 32'h0000_0300);
		wait_idle();
		display_byte <= 8'hD2;
		chk(32'(rd[STAT_DUMMY]), 32'h0000_0001);
		apb(1'b1, OFS_CMD, 32'h0000_0300);
		wait_idle();
		chk(32'(rd[15:8]), 32'h0000_004B);
		chk(32'(rd[STAT_DUMMY]), 32'h0000_0000);
		apb(1'b1, OFS_CTRL, 32'h0000_0003);
		apb(1'b1, OFS_CMD, 32'h0000_0300);
		wait_idle();
		chk(32'(rd[15:8]), 32'h0000_00D2);
		apb(1'b1, OFS_CTRL, 32'h0000_0000);
		apb(1'b1, OFS_CMD, 32'h0000_0300);
		wait_idle();
		chk(n_taken, 32'h0000_0003);
		apb(1'b1, OFS_CTRL, 32'h0000_0005);
		count_clk();
		chk(32'(o_master), 32'h0000_0001);
		chk(toggles, 32'(40 / CL_HALF));
		apb(1'b1, OFS_CTRL, 32'h0000_0001);
		count_clk();
		chk(32'(o_master), 32'h0000_0000);
		chk(toggles, 32'h0000_0000);
		apb(1'b1, OFS_CTRL, 32'h0000_0009);
		repeat (8) @(posedge i_link_clk);
		chk(32'(o_byte), 32'h0000_0000);
		apb(1'b1, OFS_CTRL, 32'h0000_0001);
		apb(1'b1, OFS_CMD, 32'h0000_0122);
		wait_idle();
		chk(32'(got_byte), 32'h0000_0022);
		give_verdict();
	end
endmodule
